// ---- design/espt_consts.svh ----
// constants for the encoder speed and park transform block
`ifndef ESPT_CONSTS_SVH
`define ESPT_CONSTS_SVH
`define ESPT_EDGES_PER_REV 16'h1000
`define ESPT_SPEED_STEP_RST 8'h1c
`define ESPT_KSPEED_RST 16'h0be7
`define ESPT_INV_ROOT3 16'h093d
`define ESPT_COS_OFFSET 8'h40
`define ESPT_ADDR_MASK 8'hff
`define ESPT_ANGLE_SHIFT 8
`define ESPT_FRAC_BITS 12
`define ESPT_KSPEED_FRAC 8
`endif

// ---- design/espt_pkg.sv ----
// types shared by the encoder speed and park transform block
package espt_pkg;
  typedef logic signed [15:0] espt_q412_t;
  typedef enum logic [3:0] {
    ESPT_IDLE = 4'h1,
    ESPT_SINE = 4'h2,
    ESPT_PARK = 4'h4,
    ESPT_DONE = 4'h8
  } espt_state_e;
endpackage

// ---- design/espt_quad_decoder.sv ----
// quadrature decoder: four counts per channel pulse
`timescale 1ns/1ps
`default_nettype none
module espt_quad_decoder (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic encA,
  input wire logic encB,
  output logic [15:0] decoderTimerCount
);
  import espt_pkg::*;
  typedef struct packed {
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic stableA;
    logic stableB;
    logic [15:0] count;
  } espt_qd_s;
  espt_qd_s st_reg;
  espt_qd_s st_next;
  logic newA;
  logic newB;
  always_comb begin
    st_next = st_reg;
    newA = st_reg.stableA;
    newB = st_reg.stableB;
    st_next.syncA = {st_reg.syncA[1:0], encA};
    st_next.syncB = {st_reg.syncB[1:0], encB};
    if (st_reg.syncA[1] == st_reg.syncA[2]) begin
      newA = st_reg.syncA[2];
    end
    if (st_reg.syncB[1] == st_reg.syncB[2]) begin
      newB = st_reg.syncB[2];
    end
    st_next.stableA = newA;
    st_next.stableB = newB;
    // an edge of either channel counts, edges of both in one cycle count once; direction from phase relation
    if ((newA != st_reg.stableA) || (newB != st_reg.stableB)) begin
      if ((newA ^ st_reg.stableB) != 1'b0) begin
        st_next.count = st_reg.count + 16'h0001;
      end else begin
        st_next.count = st_reg.count - 16'h0001;
      end
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end
  assign decoderTimerCount = st_reg.count;
  edge_counts_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clkEn && (st_next.stableA != st_reg.stableA) && (st_next.stableB == st_reg.stableB))
    |=> (st_reg.count != $past(st_reg.count))) else $error("edge not counted");
endmodule
`default_nettype wire

// ---- design/espt_sine_table.sv ----
// 256-entry sine table over one electrical turn, 4.12 entries
`timescale 1ns/1ps
`default_nettype none
module espt_sine_table (
  input wire logic [7:0] sineAddr,
  output logic [15:0] sineValue
);
  import espt_pkg::*;
  // table built from a quarter wave so all 256 entries stay exact constants
  function automatic logic [15:0] quarterWave(input logic [5:0] i);
    logic [15:0] q [0:63];
    q = '{16'h0000,16'h0065,16'h00c9,16'h012d,16'h0191,16'h01f5,16'h0259,16'h02bc,
          16'h031f,16'h0381,16'h03e3,16'h0444,16'h04a5,16'h0505,16'h0564,16'h05c2,
          16'h061f,16'h067c,16'h06d7,16'h0732,16'h078b,16'h07e3,16'h083a,16'h088f,
          16'h08e4,16'h0937,16'h0988,16'h09d8,16'h0a26,16'h0a73,16'h0abf,16'h0b08,
          16'h0b50,16'h0b97,16'h0bdb,16'h0c1e,16'h0c5e,16'h0c9d,16'h0cda,16'h0d15,
          16'h0d4e,16'h0d85,16'h0db9,16'h0dec,16'h0e1c,16'h0e4b,16'h0e77,16'h0ea1,
          16'h0ec8,16'h0eee,16'h0f11,16'h0f31,16'h0f50,16'h0f6c,16'h0f85,16'h0f9c,
          16'h0fb1,16'h0fc4,16'h0fd4,16'h0fe1,16'h0fec,16'h0ff5,16'h0ffb,16'h0fff};
    quarterWave = q[i];
  endfunction
  function automatic logic [15:0] sineOf(input logic [7:0] a);
    logic [5:0] i;
    logic [15:0] m;
    i = a[6] ? (6'h3f - a[5:0] + 6'h01) : a[5:0];
    m = (a[6] && (a[5:0] == 6'h00)) ? 16'h1000 : quarterWave(i);
    sineOf = a[7] ? (16'h0000 - m) : m;
  endfunction
  // table address is the index; contents are fixed at elaboration
  assign sineValue = sineOf(sineAddr);
endmodule
`default_nettype wire

// ---- design/espt_top.sv ----
// encoder position/speed measurement and clarke/park current transform
`include "espt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module espt_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic encA,
  input wire logic encB,
  input wire logic pwmTick,
  input wire logic [7:0] speedStepPeriod,
  input wire logic [15:0] speedScale,
  input wire espt_pkg::espt_q412_t phaseA,
  input wire espt_pkg::espt_q412_t phaseB,
  input wire logic [15:0] rotorAngle,
  output logic [15:0] position,
  output logic signed [15:0] positionIncrement,
  output espt_pkg::espt_q412_t speed,
  output logic speedValid,
  output espt_pkg::espt_q412_t alphaCurrent,
  output espt_pkg::espt_q412_t betaCurrent,
  output espt_pkg::espt_q412_t directAxisCurrent,
  output espt_pkg::espt_q412_t quadratureAxisCurrent,
  output logic transformValid
);
  import espt_pkg::*;
  typedef struct packed {
    logic [15:0] countOld;
    logic [15:0] position;
    logic signed [15:0] incr;
    logic signed [15:0] edgeAccum;
    logic [7:0] stepCount;
    logic signed [15:0] speedTmp;
    logic signed [15:0] speed;
    logic speedValid;
    logic calcSpeed;
    espt_state_e fsm;
    logic [7:0] index;
    logic signed [15:0] sinVal;
    logic signed [15:0] cosVal;
    logic signed [15:0] alpha;
    logic signed [15:0] beta;
    logic signed [15:0] dOut;
    logic signed [15:0] qOut;
    logic tValid;
  } espt_top_s;
  espt_top_s st_reg;
  espt_top_s st_next;
  logic [15:0] decoderTimerCount;
  logic [7:0] tableAddr;
  logic [15:0] tableData;
  logic pwmSeen;

  // full-precision q4.12 sum reduced by dropping fraction bits, no rounding
  function automatic logic signed [15:0] truncSum(input logic signed [32:0] s);
    truncSum = s[`ESPT_FRAC_BITS +: 16];
  endfunction

  espt_quad_decoder u_dec (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .encA(encA),
    .encB(encB),
    .decoderTimerCount(decoderTimerCount)
  );
  espt_sine_table u_tab (
    .sineAddr(tableAddr),
    .sineValue(tableData)
  );

  // table is shared between sine and cosine, so lookups run in two steps
  assign tableAddr = (st_reg.fsm == ESPT_PARK) ? 8'((st_reg.index + `ESPT_COS_OFFSET) & `ESPT_ADDR_MASK)
                                               : st_reg.index;
  assign pwmSeen = pwmTick;

  always_comb begin
    logic signed [16:0] posSum;
    logic signed [16:0] betaSum;
    logic signed [32:0] dSum;
    logic signed [32:0] qSum;
    logic signed [31:0] spdProd;
    logic signed [15:0] incrNow;
    posSum = '0;
    betaSum = '0;
    dSum = '0;
    qSum = '0;
    spdProd = '0;
    incrNow = '0;
    st_next = st_reg;
    st_next.speedValid = 1'b0;
    st_next.tValid = 1'b0;
    st_next.calcSpeed = 1'b0;
    if (pwmSeen) begin
      incrNow = $signed(decoderTimerCount - st_reg.countOld);
      st_next.incr = incrNow;
      st_next.countOld = decoderTimerCount;
      posSum = $signed({1'b0, st_reg.position}) + {incrNow[15], incrNow};
      if (posSum < 17'sd0) begin
        posSum = posSum + $signed({1'b0, `ESPT_EDGES_PER_REV});
      end
      if (posSum >= $signed({1'b0, `ESPT_EDGES_PER_REV})) begin
        posSum = posSum - $signed({1'b0, `ESPT_EDGES_PER_REV});
      end
      st_next.position = posSum[15:0];
      if ((st_reg.stepCount + 8'h01) == speedStepPeriod) begin
        st_next.speedTmp = st_reg.edgeAccum + incrNow;
        st_next.edgeAccum = '0;
        st_next.stepCount = '0;
        st_next.calcSpeed = 1'b1;
      end else begin
        st_next.edgeAccum = st_reg.edgeAccum + incrNow;
        st_next.stepCount = st_reg.stepCount + 8'h01;
      end
      st_next.index = rotorAngle[`ESPT_ANGLE_SHIFT +: 8];
      st_next.alpha = phaseA;
      betaSum = {phaseB, 1'b0} + {phaseA[15], phaseA};
      st_next.beta = truncSum(33'(betaSum * $signed({1'b0, `ESPT_INV_ROOT3})));
      st_next.fsm = ESPT_SINE;
    end
    if (st_reg.calcSpeed) begin
      spdProd = st_reg.speedTmp * $signed({1'b0, speedScale[14:0]});
      st_next.speed = spdProd[`ESPT_KSPEED_FRAC +: 16];
      st_next.speedValid = 1'b1;
    end
    case (st_reg.fsm)
      ESPT_IDLE: begin
      end
      ESPT_SINE: begin
        if (!pwmSeen) begin
          st_next.sinVal = $signed(tableData);
          st_next.fsm = ESPT_PARK;
        end
      end
      ESPT_PARK: begin
        if (!pwmSeen) begin
          st_next.cosVal = $signed(tableData);
          st_next.fsm = ESPT_DONE;
        end
      end
      ESPT_DONE: begin
        dSum = 33'(st_reg.alpha * st_reg.cosVal) + 33'(st_reg.beta * st_reg.sinVal);
        qSum = 33'(st_reg.beta * st_reg.cosVal) - 33'(st_reg.alpha * st_reg.sinVal);
        st_next.dOut = truncSum(dSum);
        st_next.qOut = truncSum(qSum);
        st_next.tValid = 1'b1;
        if (!pwmSeen) begin
          st_next.fsm = ESPT_IDLE;
        end
      end
      default: begin
        st_next.fsm = ESPT_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
      st_reg.fsm <= ESPT_IDLE;
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  assign position = st_reg.position;
  assign positionIncrement = st_reg.incr;
  assign speed = st_reg.speed;
  assign speedValid = st_reg.speedValid;
  assign alphaCurrent = st_reg.alpha;
  assign betaCurrent = st_reg.beta;
  assign directAxisCurrent = st_reg.dOut;
  assign quadratureAxisCurrent = st_reg.qOut;
  assign transformValid = st_reg.tValid;

  sequence pwmSeq;
    clkEn && pwmTick;
  endsequence
  pos_range_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_reg.position < `ESPT_EDGES_PER_REV) else $error("position out of range");
  incr_diff_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pwmSeq |=> (st_reg.incr == $signed($past(decoderTimerCount) - $past(st_reg.countOld)))) else $error("bad increment");
  old_keep_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pwmSeq |=> (st_reg.countOld == $past(decoderTimerCount))) else $error("count not kept");
  speed_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (pwmSeq and ((st_reg.stepCount + 8'h01) == speedStepPeriod)) |=> (st_reg.stepCount == 8'h00)) else $error("no restart");
  speed_valid_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (clkEn && st_reg.calcSpeed) |=> st_reg.speedValid) else $error("speed not produced");
  alpha_copy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pwmSeq |=> (st_reg.alpha == $past(phaseA))) else $error("alpha mismatch");
  cos_addr_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (st_reg.fsm == ESPT_PARK) |-> (tableAddr == 8'(st_reg.index + `ESPT_COS_OFFSET))) else $error("cos address");
  index_shift_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pwmSeq |=> (st_reg.index == $past(rotorAngle[15:8]))) else $error("index");
endmodule
`default_nettype wire

// ---- verification/espt_encoder_model.sv ----
// quadrature encoder shaft model, moved one edge per request
`timescale 1ns/1ps
`default_nettype none
module espt_encoder_model (
  input wire logic ref_clk,
  input wire logic stepReq,
  input wire logic stepFwd,
  output logic encA,
  output logic encB
);
  logic [1:0] phaseReg = 2'h0;
  always_ff @(posedge ref_clk) begin
    if (stepReq) begin
      phaseReg <= stepFwd ? phaseReg + 2'h1 : phaseReg - 2'h1;
    end
  end
  // gray order: only one channel moves per step, so channels stay a quarter period apart
  assign encA = phaseReg[1] ^ phaseReg[0];
  assign encB = phaseReg[1];
endmodule
`default_nettype wire

// ---- verification/espt_top_test.sv ----
// self-checking bench for the encoder speed and park transform block
`include "espt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module espt_top_test;
  import espt_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pwmTick = 1'b0;
  logic clkEn = 1'b1;
  logic stepReq = 1'b0;
  logic stepFwd = 1'b1;
  logic encA;
  logic encB;
  espt_q412_t phaseA = 16'h0000;
  espt_q412_t phaseB = 16'h0000;
  logic [15:0] rotorAngle = 16'h0000;
  logic [15:0] position;
  logic signed [15:0] positionIncrement;
  espt_q412_t speed;
  logic speedValid;
  espt_q412_t alphaCurrent;
  espt_q412_t betaCurrent;
  espt_q412_t directAxisCurrent;
  espt_q412_t quadratureAxisCurrent;
  logic transformValid;
  logic sawSpeed;
  logic sawXform;
  int err_total = 0;
  int checks = 0;
  logic [15:0] aTab[4] = '{16'h0800, 16'hf000, 16'h1234, 16'hfc00};
  logic [15:0] bTab[4] = '{16'h0400, 16'h0300, 16'hfedc, 16'hfe00};
  // low angle byte is nonzero except in 16'h8000, so a missing shift would pick a wrong entry
  logic [15:0] angTab[4] = '{16'h00ff, 16'h40ff, 16'h8000, 16'hc07f};

  espt_encoder_model shaft (.ref_clk(ref_clk), .stepReq(stepReq), .stepFwd(stepFwd), .encA(encA), .encB(encB));
  espt_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn), .encA(encA), .encB(encB),
    .pwmTick(pwmTick), .speedStepPeriod(`ESPT_SPEED_STEP_RST), .speedScale(`ESPT_KSPEED_RST),
    .phaseA(phaseA), .phaseB(phaseB), .rotorAngle(rotorAngle), .position(position),
    .positionIncrement(positionIncrement), .speed(speed), .speedValid(speedValid),
    .alphaCurrent(alphaCurrent), .betaCurrent(betaCurrent), .directAxisCurrent(directAxisCurrent),
    .quadratureAxisCurrent(quadratureAxisCurrent), .transformValid(transformValid));

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // edges spaced apart so the input synchroniser sees every one
  task automatic step(input int n, input logic fwd);
    repeat (n) begin
      @(negedge ref_clk);
      stepReq = 1'b1;
      stepFwd = fwd;
      @(negedge ref_clk);
      stepReq = 1'b0;
      repeat (2) @(negedge ref_clk);
    end
  endtask

  task automatic tick();
    repeat (8) @(negedge ref_clk);
    pwmTick = 1'b1;
    @(negedge ref_clk);
    pwmTick = 1'b0;
    sawSpeed = 1'b0;
    sawXform = 1'b0;
    repeat (12) begin
      if (speedValid === 1'b1) sawSpeed = 1'b1;
      if (transformValid === 1'b1) sawXform = 1'b1;
      @(negedge ref_clk);
    end
    if (!sawXform) begin
      err_total++;
      $display("Error at %0t: transform never completed", $time);
      tally_and_finish();
    end
  endtask

  function automatic logic [15:0] betaOf(input logic signed [15:0] a, input logic signed [15:0] b);
    int s;
    s = (2 * int'(b) + int'(a)) * int'(`ESPT_INV_ROOT3);
    return 16'(s >>> 12);
  endfunction

  initial begin
    logic [15:0] al;
    logic [15:0] be;
    logic [15:0] d;
    logic [15:0] q;
    repeat (5) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    chk(position, 16'h0000);
    for (int n = 1; n <= 28; n++) begin
      step(1, 1'b1);
      tick();
      chk(16'(sawSpeed), 16'(n == 28));
    end
    chk(speed, 16'h014d);
    chk(positionIncrement, 16'h0001);
    $display("speed loop test done");
    step(30, 1'b0);
    tick();
    chk(positionIncrement, 16'hffe2);
    chk(position, 16'h0ffe);
    step(5, 1'b1);
    tick();
    chk(positionIncrement, 16'h0005);
    chk(position, 16'h0003);
    $display("position wrap test done");
    // a tick while frozen must be lost and leave position and increment standing
    clkEn = 1'b0;
    pwmTick = 1'b1;
    @(negedge ref_clk);
    pwmTick = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(position, 16'h0003);
    chk(positionIncrement, 16'h0005);
    clkEn = 1'b1;
    $display("freeze test done");
    for (int i = 0; i < 4; i++) begin
      phaseA = aTab[i];
      phaseB = bTab[i];
      rotorAngle = angTab[i];
      tick();
      al = aTab[i];
      be = betaOf(aTab[i], bTab[i]);
      case (i)
        0: begin d = al; q = be; end
        1: begin d = be; q = -al; end
        2: begin d = -al; q = -be; end
        default: begin d = -be; q = al; end
      endcase
      chk(alphaCurrent, al);
      chk(betaCurrent, be);
      chk(directAxisCurrent, d);
      chk(quadratureAxisCurrent, q);
    end
    $display("transform test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
